/* File: verilog/chopper_channel.sv */
/*
 * Constant-current chopper control for one H-bridge channel: phase sequencing,
 * gate patterns, noise blanking and over-current / thermal halt.
 * Assumes all inputs except MCLK and RST_N are asynchronous pins or analog
 * comparator outputs; the gate outputs feed level shifters directly.
 */
`timescale 1ns/1ps
`include "chop_consts.svh"

module chopper_channel (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Reference oscillator pin
	input wire logic OSC_IN,
	// Controller inputs
	input wire logic CH_CLK,
	input wire logic CH_ENABLE,
	input wire logic DIR,
	input wire logic MODE_DC,
	input wire logic STANDBY,
	input wire logic VM_POR,
	// Analog sense inputs
	input wire logic CURRENT_LIMIT_REACHED,
	input wire logic ZERO_CURRENT,
	input wire logic OVERCURRENT,
	input wire logic THERMAL_SHUTDOWN,
	// Bridge gates
	output logic HIGH_SIDE_ONE,
	output logic HIGH_SIDE_TWO,
	output logic LOW_SIDE_ONE,
	output logic LOW_SIDE_TWO,
	// Status
	output chop_pkg::chop_state_e CHOP_STATE,
	output logic NOISE_BLANK_WINDOW,
	output logic OVERCURRENT_SHUTDOWN
);
	import chop_pkg::*;

	localparam logic [`ANALOG_CNT_W-1:0] ANALOG_CYC = `ANALOG_CNT_W'(`ANALOG_BLANK_CYC);

	logic [`IN_COUNT-1:0] pins, meta_q, sync_q;
	logic en_s, clk_s, dir_s, mode_s, lim_s, zero_s, oc_s, tsd_s, stby_s, por_s;
	logic tick, period_start;
	phase_t phase;
	logic clk_prev_q, en_prev_q, clk_edge, en_edge;
	chop_state_e state_q, state_d;
	logic run, drive_req, sw_evt, charge_start, blank, limit_hit;
	logic [`ANALOG_CNT_W-1:0] ana_q, ana_d;
	logic [`OSC_CNT_W-1:0] dig_q, dig_d, db_q, db_d, oc_cnt_q, oc_cnt_d;
	logic halt_q, halt_d, trip;
	gate_t gate_q, gate_d, tgt;

	// Gate pattern for a phase and direction; slow decay is the same both ways
	function automatic gate_t gate_for(chop_state_e st, logic rev);
		gate_t g;
		g = `GATE_OFF;
		unique case (st)
			PH_OFF: g = `GATE_OFF;
			PH_CHARGE: g = rev ? `GATE_CHARGE_REV : `GATE_CHARGE_FWD;
			PH_SLOW: g = `GATE_SLOW;
			PH_FAST: g = rev ? `GATE_FAST_REV : `GATE_FAST_FWD;
		endcase
		return g;
	endfunction

	osc_timebase u_timebase (
		.clk(MCLK),
		.rst_n(RST_N),
		.osc_pin(OSC_IN),
		.tick(tick),
		.phase(phase),
		.period_start(period_start)
	);

	// Gather the asynchronous pins for the synchroniser
	always_comb begin
		pins = '0;
		pins[`IN_ENABLE] = CH_ENABLE;
		pins[`IN_CLK] = CH_CLK;
		pins[`IN_DIR] = DIR;
		pins[`IN_MODE_DC] = MODE_DC;
		pins[`IN_LIMIT] = CURRENT_LIMIT_REACHED;
		pins[`IN_ZERO] = ZERO_CURRENT;
		pins[`IN_OVERCUR] = OVERCURRENT;
		pins[`IN_THERMAL] = THERMAL_SHUTDOWN;
		pins[`IN_STANDBY] = STANDBY;
		pins[`IN_VM_POR] = VM_POR;
	end

	// Two flops per pin; the first stage is read only by the second
	genvar i;
	generate
		for (i = 0; i < `IN_COUNT; i++) begin : g_sync
			always_ff @(posedge MCLK) begin
				if (!RST_N) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= pins[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	assign en_s = sync_q[`IN_ENABLE];
	assign clk_s = sync_q[`IN_CLK];
	assign dir_s = sync_q[`IN_DIR];
	assign mode_s = sync_q[`IN_MODE_DC];
	assign lim_s = sync_q[`IN_LIMIT];
	assign zero_s = sync_q[`IN_ZERO];
	assign oc_s = sync_q[`IN_OVERCUR];
	assign tsd_s = sync_q[`IN_THERMAL];
	assign stby_s = sync_q[`IN_STANDBY];
	assign por_s = sync_q[`IN_VM_POR];

	// Edges of the controller PWM inputs, taken from synchronised copies
	assign clk_edge = clk_s ^ clk_prev_q;
	assign en_edge = en_s ^ en_prev_q;

	// In DC mode a low channel clock means short brake (slow decay)
	assign run = en_s & ~halt_q & ~stby_s;
	assign drive_req = ~mode_s | clk_s;
	assign blank = (ana_q != '0) | (dig_q != '0);
	assign limit_hit = lim_s & ~blank;

	// Phase sequencing; the comparator is only trusted outside the blank
	always_comb begin
		state_d = state_q;
		if (!run) begin
			state_d = PH_OFF;
		end else if (!drive_req) begin
			state_d = PH_SLOW;
		end else if (period_start || state_q == PH_OFF) begin
			state_d = PH_CHARGE;
		end else begin
			unique case (state_q)
				PH_CHARGE: begin
					// DC mode holds charge for the first periods; a late limit skips slow decay
					if (limit_hit && !(mode_s && phase < `CHARGE_MIN_OSC)) begin
						state_d = (phase >= `FAST_START) ? PH_FAST : PH_SLOW;
					end
				end
				PH_SLOW: begin
					if (phase >= `FAST_START) begin
						state_d = PH_FAST;
					end
				end
				PH_FAST: begin
					if (zero_s && !blank) begin
						state_d = PH_CHARGE;
					end
				end
				PH_OFF: state_d = PH_CHARGE;
			endcase
		end
	end

	assign sw_evt = (state_d != state_q);
	assign charge_start = (state_d == PH_CHARGE) && (state_q != PH_CHARGE);

	// Blank windows and dead band counters
	always_comb begin
		ana_d = ana_q;
		if (sw_evt) begin
			ana_d = ANALOG_CYC;
		end else if (ana_q != '0) begin
			ana_d = ana_q - `ANALOG_CNT_W'(1);
		end
		dig_d = dig_q;
		if (!mode_s) begin
			dig_d = '0;
		end else if (clk_edge || en_edge || charge_start) begin
			dig_d = `DIG_BLANK_OSC;
		end else if (tick && dig_q != '0) begin
			dig_d = dig_q - `OSC_CNT_W'(1);
		end
		db_d = db_q;
		if (sw_evt) begin
			db_d = `OC_DEADBAND_OSC;
		end else if (tick && db_q != '0) begin
			db_d = db_q - `OSC_CNT_W'(1);
		end
	end

	// Over-current counts oscillator periods while the sense stays high.
	// Counting goes on inside the dead band so a fault present at switching
	// still trips within eight periods; only the trip itself is masked.
	always_comb begin
		oc_cnt_d = oc_cnt_q;
		if (!oc_s) begin
			oc_cnt_d = '0;
		end else if (tick && oc_cnt_q <= `OC_TRIP_OSC) begin
			oc_cnt_d = oc_cnt_q + `OSC_CNT_W'(1);
		end
		// The first tick may land just after the fault starts, so one tick more
		// than the trip count keeps four whole periods before shutdown
		trip = oc_s && (oc_cnt_q > `OC_TRIP_OSC) && (db_q == '0);
		// A fault in the same cycle as a clear wins; the clear acts once it is gone
		if (trip || tsd_s) begin
			halt_d = 1'b1;
		end else if (por_s || stby_s) begin
			halt_d = 1'b0;
		end else begin
			halt_d = halt_q;
		end
	end

	// Gates: any change of pattern passes through all-off for one cycle,
	// trading one cycle of drive for freedom from shoot-through
	always_comb begin
		// Loss of run (halt, standby, enable) drops the gates at once, not a cycle after the phase
		tgt = run ? gate_for(state_q, dir_s) : `GATE_OFF;
		if (tgt == `GATE_OFF || gate_q == `GATE_OFF || gate_q == tgt) begin
			gate_d = tgt;
		end else begin
			gate_d = `GATE_OFF;
		end
	end

	// Register all state
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			clk_prev_q <= 1'b0;
			en_prev_q <= 1'b0;
			state_q <= PH_OFF;
			ana_q <= '0;
			dig_q <= '0;
			db_q <= '0;
			oc_cnt_q <= '0;
			halt_q <= 1'b0;
			gate_q <= `GATE_OFF;
		end else begin
			clk_prev_q <= clk_s;
			en_prev_q <= en_s;
			state_q <= state_d;
			ana_q <= ana_d;
			dig_q <= dig_d;
			db_q <= db_d;
			oc_cnt_q <= oc_cnt_d;
			halt_q <= halt_d;
			gate_q <= gate_d;
		end
	end

	assign HIGH_SIDE_ONE = gate_q[`GATE_HS1];
	assign HIGH_SIDE_TWO = gate_q[`GATE_HS2];
	assign LOW_SIDE_ONE = gate_q[`GATE_LS1];
	assign LOW_SIDE_TWO = gate_q[`GATE_LS2];
	assign CHOP_STATE = state_q;
	assign NOISE_BLANK_WINDOW = blank;
	assign OVERCURRENT_SHUTDOWN = halt_q;

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	no_shoot_through_a: assert property (!(gate_q[`GATE_HS1] && gate_q[`GATE_LS1]) && !(gate_q[`GATE_HS2] && gate_q[`GATE_LS2]))
		else $error("both switches of a half-bridge on");
	gate_follow_a: assert property ((tgt == $past(tgt)) && ($past(tgt) == $past(tgt, 2)) |-> gate_q == tgt)
		else $error("gates do not settle to the phase pattern");
	reverse_charge_a: assert property (state_q == PH_CHARGE && dir_s && $stable(state_q) && $stable(dir_s) ##1 $stable(state_q) && $stable(dir_s) |-> gate_q == `GATE_CHARGE_REV)
		else $error("reverse charge pattern wrong");
	period_charge_a: assert property (period_start && run && drive_req |=> state_q == PH_CHARGE)
		else $error("chopping period did not start in charge");
	slow_to_fast_a: assert property (state_q == PH_SLOW && phase >= `FAST_START && run && drive_req && !period_start |=> state_q == PH_FAST)
		else $error("slow decay missed the fast decay point");
	fast_zero_a: assert property (state_q == PH_FAST && zero_s && !blank && run && drive_req |=> state_q == PH_CHARGE)
		else $error("zero current did not end fast decay");
	analog_blank_a: assert property (sw_evt |=> ana_q == ANALOG_CYC ##1 blank)
		else $error("analog blank not started on switching");
	step_no_digital_a: assert property (!mode_s |=> dig_q == '0)
		else $error("digital blank active in stepping mode");
	dc_blank_start_a: assert property (mode_s && (clk_edge || en_edge) |=> dig_q == `DIG_BLANK_OSC)
		else $error("digital blank not restarted on input edge");
	dc_charge_hold_a: assert property (state_q == PH_CHARGE && mode_s && phase < `CHARGE_MIN_OSC && run && drive_req |=> state_q == PH_CHARGE)
		else $error("charge left during minimum charge time");
	dead_band_a: assert property (db_q != '0 && !tsd_s && !halt_q |=> !halt_q)
		else $error("over-current tripped inside dead band");
	trip_bound_a: assert property (oc_s && oc_cnt_q > `OC_TRIP_OSC && db_q == '0 && !por_s && !stby_s |=> halt_q ##1 gate_q == `GATE_OFF)
		else $error("sustained over-current did not halt outputs");
	halt_latch_a: assert property (halt_q && !por_s && !stby_s |=> halt_q)
		else $error("halt released without supply reset or standby");
	thermal_halt_a: assert property (tsd_s && !por_s && !stby_s |=> halt_q ##1 gate_q == `GATE_OFF)
		else $error("thermal shutdown did not halt outputs");

	trip_seen_c: cover property (!halt_q ##1 halt_q);
	zero_recharge_c: cover property (state_q == PH_FAST ##1 state_q == PH_CHARGE && !period_start);
	direct_fast_c: cover property (state_q == PH_CHARGE ##1 state_q == PH_FAST);
	dc_blank_c: cover property (mode_s && dig_q == `DIG_BLANK_OSC);
endmodule

/* File: pkg/chop_consts.svh */
/*
 * Timing counts, gate patterns and field positions for the chopper channel.
 * Assumes a 100 MHz system clock and a reference oscillator near 1.6 MHz.
 */
`ifndef CHOP_CONSTS_SVH
`define CHOP_CONSTS_SVH

// System clock rate
`define MCLK_MHZ 100
// Analog blank window, shortest figure, in ns
`define ANALOG_BLANK_NS 450
// Analog blank in clock cycles, rounded up
`define ANALOG_BLANK_CYC ((`ANALOG_BLANK_NS * `MCLK_MHZ + 999) / 1000)
`define ANALOG_CNT_W 6

// Reference oscillator periods per chopping period (1.6 MHz / 100 kHz)
`define OSC_PER_CHOP 16
`define PHASE_W 4
// Last oscillator period of a chopping period
`define PHASE_LAST 4'hF
// 37.5 % of 16 periods is fast decay, so fast decay starts at period 10
`define FAST_START 4'hA
// Charge held for the first periods in brushed-DC mode
`define CHARGE_MIN_OSC 4'h4

// Digital blank, over-current dead band and trip counts, in oscillator periods
`define OSC_CNT_W 3
`define DIG_BLANK_OSC 3'h4
`define OC_DEADBAND_OSC 3'h4
`define OC_TRIP_OSC 3'h4

// Gate bit positions in a pattern
`define GATE_HS1 3
`define GATE_HS2 2
`define GATE_LS1 1
`define GATE_LS2 0

// Gate patterns {hs1, hs2, ls1, ls2}
`define GATE_OFF 4'h0
`define GATE_CHARGE_FWD 4'h9
`define GATE_FAST_FWD 4'h6
`define GATE_CHARGE_REV 4'h6
`define GATE_FAST_REV 4'h9
`define GATE_SLOW 4'h3

// Positions of the synchronised inputs
`define IN_ENABLE 0
`define IN_CLK 1
`define IN_DIR 2
`define IN_MODE_DC 3
`define IN_LIMIT 4
`define IN_ZERO 5
`define IN_OVERCUR 6
`define IN_THERMAL 7
`define IN_STANDBY 8
`define IN_VM_POR 9
`define IN_COUNT 10

`endif

/* File: pkg/chop_pkg.sv */
/*
 * Types shared by the chopper channel and its timebase.
 * Assumes chop_consts.svh is on the include path.
 */
package chop_pkg;
	// Bridge phase of the chopper
	typedef enum logic [1:0] {PH_OFF, PH_CHARGE, PH_SLOW, PH_FAST} chop_state_e;
	// Four gate enables {hs1, hs2, ls1, ls2}
	typedef logic [3:0] gate_t;
	// Position within a chopping period, in oscillator periods
	typedef logic [3:0] phase_t;
endpackage

/* File: verilog/osc_timebase.sv */
/*
 * Timebase from the external RC reference oscillator: synchroniser, edge tick
 * and position within the chopping period.
 * Assumes the oscillator pin is asynchronous and much slower than MCLK.
 */
`timescale 1ns/1ps
`include "chop_consts.svh"

module osc_timebase (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Oscillator pin
	input wire logic osc_pin,
	// Timebase outputs
	output logic tick,
	output chop_pkg::phase_t phase,
	output logic period_start
);
	import chop_pkg::*;

	logic sync1_q, sync2_q, prev_q;
	logic tick_q, tick_d;
	phase_t phase_q, phase_d;
	logic start_q, start_d;

	// Next values: one tick per rising oscillator edge, period counts ticks
	always_comb begin
		tick_d = sync2_q & ~prev_q;
		phase_d = phase_q;
		start_d = 1'b0;
		if (tick_d) begin
			phase_d = phase_q + 4'h1;
			start_d = (phase_q == `PHASE_LAST);
		end
	end

	// Only sync2_q is read by logic; sync1_q feeds it alone
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			prev_q <= 1'b0;
			tick_q <= 1'b0;
			phase_q <= 4'h0;
			start_q <= 1'b0;
		end else begin
			sync1_q <= osc_pin;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			tick_q <= tick_d;
			phase_q <= phase_d;
			start_q <= start_d;
		end
	end

	assign tick = tick_q;
	assign phase = phase_q;
	assign period_start = start_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// A period start wraps the position to zero
	period_wrap_a: assert property (period_start |-> phase == 4'h0)
		else $error("period start without phase zero");
	// Tick is a single-cycle pulse
	tick_pulse_a: assert property (tick |=> !tick)
		else $error("oscillator tick longer than one cycle");
endmodule

/* File: dv/chop_ctrl_model.sv */
/* Controller-side model: free-running reference oscillator and the channel clock and enable pins.
   Assumes the bench sets level commands just after the clock edge. */
`timescale 1ns/1ps
module chop_ctrl_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Commands from the bench
	input wire logic en_cmd,
	input wire logic clk_cmd,
	// Pins to the channel
	output logic osc_out,
	output logic ch_clk,
	output logic ch_enable
);
	logic [4:0] div_q = 5'h00;
	initial osc_out = 1'b0;
	initial ch_clk = 1'b0;
	initial ch_enable = 1'b0;
	// The RC oscillator runs free, 62 cycles a period; pins follow commands one edge late
	always @(posedge clk) begin
		div_q <= #1 (div_q == 5'h1E) ? 5'h00 : div_q + 5'h01;
		if (div_q == 5'h1E) osc_out <= #1 ~osc_out;
		ch_clk <= #1 rst_n & clk_cmd;
		ch_enable <= #1 rst_n & en_cmd;
	end
endmodule

/* File: dv/chopper_decay_blank_control_tb_top.sv */
/* Self-checking bench for the chopper channel: phases, gate patterns, blank windows,
   chop period and halt latch. Assumes chop_pkg is compiled first. */
`timescale 1ns/1ps
module chopper_decay_blank_control_tb_top;
	import chop_pkg::*;
	typedef struct {string nm; bit span; int lo; int hi;} note_s;
	logic mclk = 1'b0, rst_n = 1'b0, dir = 1'b0, mode_dc = 1'b0, standby = 1'b0, vm_por = 1'b0;
	logic lim = 1'b0, zero = 1'b0, oc = 1'b0, therm = 1'b0, en_cmd = 1'b0, clk_cmd = 1'b0;
	logic osc_in, ch_clk, ch_enable, blank, halt;
	wire [3:0] gates;
	chop_state_e chop_state;
	int bad_count = 0, comparisons = 0, seed = 52, cyc = 0, t0, n;
	note_s exp_q[$];
	note_s nt;
	logic [31:0] seen;
	event seen_ev;

	chop_ctrl_model u_ctrl (.clk(mclk), .rst_n(rst_n), .en_cmd(en_cmd), .clk_cmd(clk_cmd), .osc_out(osc_in),
		.ch_clk(ch_clk), .ch_enable(ch_enable));
	chopper_channel u_dut (.MCLK(mclk), .RST_N(rst_n), .OSC_IN(osc_in), .CH_CLK(ch_clk), .CH_ENABLE(ch_enable),
		.DIR(dir), .MODE_DC(mode_dc), .STANDBY(standby), .VM_POR(vm_por), .CURRENT_LIMIT_REACHED(lim),
		.ZERO_CURRENT(zero), .OVERCURRENT(oc), .THERMAL_SHUTDOWN(therm), .HIGH_SIDE_ONE(gates[3]),
		.HIGH_SIDE_TWO(gates[2]), .LOW_SIDE_ONE(gates[1]), .LOW_SIDE_TWO(gates[0]), .CHOP_STATE(chop_state),
		.NOISE_BLANK_WINDOW(blank), .OVERCURRENT_SHUTDOWN(halt));

	// Clock and a free cycle count for spans
	always #5 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	task stop_test();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	// Driver side: note the expectation, then hand over what was seen
	task expect_show(input string nm, input bit span, input int lo, input int hi, input logic [31:0] v);
		exp_q.push_back('{nm, span, lo, hi});
		seen = v;
		->seen_ev;
	endtask
	task cmp_val(input note_s t);
		comparisons++;
		if (seen !== 32'(t.lo)) begin
			bad_count++;
			$display("ERROR %s expected %0h seen %0h", t.nm, t.lo, seen);
		end
	endtask
	task cmp_span(input note_s t);
		comparisons++;
		if ($isunknown(seen) || !((seen >= 32'(t.lo)) && (seen <= 32'(t.hi)))) begin
			bad_count++;
			$display("ERROR %s expected %0d..%0d seen %0d", t.nm, t.lo, t.hi, seen);
		end
	endtask
	// Monitor side: the oldest note pairs with each result
	always @(seen_ev) begin
		nt = exp_q.pop_front();
		if (nt.span) cmp_span(nt);
		else cmp_val(nt);
	end
	// Gates settle up to two cycles after a phase change, so look three cycles on
	task chk_gates(input string nm, input logic [3:0] g);
		step(3);
		expect_show(nm, 1'b0, g, g, {28'h0, gates});
	endtask
	// Bounded wait for a phase; n holds the cycles waited
	task wait_st(input chop_state_e s, input int lim_c);
		n = 0;
		while (chop_state !== s && n < lim_c) begin
			step(1);
			n++;
		end
		if (chop_state !== s) begin
			bad_count++;
			$display("ERROR phase wait expected %0d seen %0d", s, chop_state);
		end
	endtask
	task gap();
		step(60 + ($unsigned($random(seed)) % 64));
	endtask
	task wait_halt();
		n = 0;
		while (halt !== 1'b1 && n < 1000) begin
			step(1);
			n++;
		end
		if (halt !== 1'b1) begin
			bad_count++;
			$display("ERROR halt wait expected 1 seen %b", halt);
		end
	endtask

	// Watchdog: the run needs about 8000 cycles
	initial begin
		step(60000);
		bad_count++;
		$display("ERROR watchdog expected done seen running");
		stop_test();
	end

	initial begin
		step(12);
		rst_n = 1'b1;
		step(1);
		expect_show("reset outputs", 1'b0, 0, 0, {24'h0, halt, blank, chop_state, gates});
		$display("test reset done");
		// Stepping mode, both current directions
		for (int d = 0; d < 2; d++) begin
			dir = d[0];
			en_cmd = 1'b1;
			lim = 1'b1;
			wait_st(PH_FAST, 2000);
			lim = 1'b0;
			wait_st(PH_CHARGE, 1100);
			t0 = cyc;
			chk_gates("charge gates", d ? 4'h6 : 4'h9);
			gap();
			lim = 1'b1;
			wait_st(PH_SLOW, 10);
			lim = 1'b0;
			expect_show("limit to slow", 1'b1, 1, 6, n);
			chk_gates("slow gates", 4'h3);
			wait_st(PH_FAST, 700);
			expect_show("start to fast", 1'b1, 620, 620, cyc - t0);
			n = 0;
			while (blank === 1'b1 && n < 2000) begin
				n++;
				step(1);
			end
			expect_show("analog blank", 1'b1, 45, 45, n);
			chk_gates("fast gates", d ? 4'h9 : 4'h6);
			wait_st(PH_CHARGE, 500);
			expect_show("chop period", 1'b1, 992, 992, cyc - t0);
			gap();
			lim = 1'b1;
			wait_st(PH_SLOW, 10);
			lim = 1'b0;
			wait_st(PH_FAST, 700);
			step(50);
			zero = 1'b1;
			wait_st(PH_CHARGE, 10);
			zero = 1'b0;
			expect_show("zero to charge", 1'b1, 1, 6, n);
			en_cmd = 1'b0;
			wait_st(PH_OFF, 10);
			chk_gates("off gates", 4'h0);
			$display("test stepping dir %0d done", d);
		end
		// Brushed-DC mode: minimum charge and blank after a channel clock edge
		mode_dc = 1'b1;
		clk_cmd = 1'b1;
		en_cmd = 1'b1;
		lim = 1'b1;
		wait_st(PH_FAST, 2000);
		wait_st(PH_CHARGE, 1100);
		t0 = cyc;
		wait_st(PH_SLOW, 400);
		expect_show("dc min charge", 1'b1, 246, 254, cyc - t0);
		step(50);
		clk_cmd = 1'b0;
		step(8);
		n = 8;
		while (blank === 1'b1 && n < 2000) begin
			n++;
			step(1);
		end
		expect_show("dc clock blank", 1'b1, 185, 254, n);
		lim = 1'b0;
		mode_dc = 1'b0;
		$display("test dc done");
		// Over-current trip, latch, and thermal halt
		wait_st(PH_CHARGE, 1100);
		lim = 1'b1;
		wait_st(PH_FAST, 1100);
		lim = 1'b0;
		wait_st(PH_CHARGE, 1100);
		step(60);
		oc = 1'b1;
		wait_halt();
		expect_show("trip delay", 1'b1, 248, 504, n);
		oc = 1'b0;
		step(300);
		expect_show("halt held", 1'b0, 'h40, 'h40, {25'h0, halt, chop_state, gates});
		standby = 1'b1;
		step(5);
		standby = 1'b0;
		step(3);
		expect_show("standby clear", 1'b0, 0, 0, {31'h0, halt});
		therm = 1'b1;
		wait_halt();
		expect_show("thermal trip", 1'b1, 1, 6, n);
		therm = 1'b0;
		step(20);
		expect_show("thermal held", 1'b0, 'h40, 'h40, {25'h0, halt, chop_state, gates});
		vm_por = 1'b1;
		step(5);
		vm_por = 1'b0;
		step(3);
		expect_show("supply clear", 1'b0, 0, 0, {31'h0, halt});
		$display("test halt done");
		step(2);
		stop_test();
	end
endmodule
